// *** hw/dpa_port_ctrl.v ***
// Host-side controller driving one port of an asynchronous dual-port static memory.
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`include "dpa_defines.vh"
module dpa_port_ctrl (
	clk_sys,
	rst_n,
	avs_address,
	avs_read,
	avs_write,
	avs_writedata,
	avs_readdata,
	avs_waitrequest,
	left_low_active_select_n,
	left_high_active_select,
	left_write_not_read,
	left_output_enable_n,
	left_flag_select_n,
	left_address_bus,
	left_data_bus_in,
	left_data_bus_out,
	left_data_bus_oe_n,
	left_contention_flag_n,
	left_attention_flag_n,
	cascade_master
);
	input wire clk_sys;
	input wire rst_n;
	input wire [3:0] avs_address;
	input wire avs_read;
	input wire avs_write;
	input wire [31:0] avs_writedata;
	output reg [31:0] avs_readdata;
	output wire avs_waitrequest;
	output reg left_low_active_select_n;
	output reg left_high_active_select;
	output reg left_write_not_read;
	output reg left_output_enable_n;
	output reg left_flag_select_n;
	output reg [15:0] left_address_bus;
	input wire [7:0] left_data_bus_in;
	output reg [7:0] left_data_bus_out;
	output reg left_data_bus_oe_n;
	input wire left_contention_flag_n;
	input wire left_attention_flag_n;
	output wire cascade_master;

	localparam ST_IDLE = 4'b0001;
	localparam ST_SETUP = 4'b0010;
	localparam ST_ACCESS = 4'b0100;
	localparam ST_HOLD = 4'b1000;

	reg [3:0] state_ff;
	reg [3:0] cnt_ff;
	reg wr_ff;
	reg flag_ff;
	reg master_ff;
	reg [15:0] addr_ff;
	reg [7:0] wdata_ff;
	reg [7:0] rdata_ff;
	reg cont_ff;
	reg err_ff;
	reg rd_pend_ff;
	wire cont_sync;
	wire attn_sync;
	wire [7:0] data_sync;
	wire busy;

	// Both flags are inverted ahead of their synchronisers, so the reset value matches an idle pin.
	// That keeps a false attention or contention report out of the first cycles after reset.
	dpa_sync u_sync_cont (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.d_in(~left_contention_flag_n),
		.q_out(cont_sync)
	);
	dpa_sync u_sync_attn (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.d_in(~left_attention_flag_n),
		.q_out(attn_sync)
	);
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_dsync
			dpa_sync u_sync_data (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.d_in(left_data_bus_in[gi]),
				.q_out(data_sync[gi])
			);
		end
	endgenerate

	assign busy = (state_ff != ST_IDLE);
	// The slave role leaves the contention flag as a device input fed by the master's.
	assign cascade_master = master_ff;
	// Writes answer at once; a read waits one cycle for registered read data.
	assign avs_waitrequest = avs_read & ~rd_pend_ff;

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			rd_pend_ff <= 1'b0;
			avs_readdata <= 32'h0;
		end else begin
			rd_pend_ff <= avs_read & ~rd_pend_ff;
			case (avs_address)
				`DPA_REG_CTRL: avs_readdata <= {28'h0, master_ff, flag_ff, wr_ff, busy};
				`DPA_REG_ADDR: avs_readdata <= {16'h0, addr_ff};
				`DPA_REG_WDATA: avs_readdata <= {24'h0, wdata_ff};
				`DPA_REG_STAT: avs_readdata <= {28'h0, err_ff, attn_sync, cont_ff, busy};
				`DPA_REG_RDATA: avs_readdata <= {24'h0, rdata_ff};
				default: avs_readdata <= 32'h0;
			endcase
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 4'h0;
			wr_ff <= 1'b0;
			flag_ff <= 1'b0;
			master_ff <= 1'b1;
			addr_ff <= 16'h0;
			wdata_ff <= 8'h0;
			rdata_ff <= 8'h0;
			cont_ff <= 1'b0;
			err_ff <= 1'b0;
			left_low_active_select_n <= 1'b1;
			left_high_active_select <= 1'b0;
			left_write_not_read <= 1'b1;
			left_output_enable_n <= 1'b1;
			left_flag_select_n <= 1'b1;
			left_address_bus <= 16'h0;
			left_data_bus_out <= 8'h0;
			left_data_bus_oe_n <= 1'b1;
		end else begin
			if (avs_write && avs_address == `DPA_REG_ADDR && !busy) begin
				addr_ff <= avs_writedata[15:0];
			end
			if (avs_write && avs_address == `DPA_REG_WDATA && !busy) begin
				wdata_ff <= avs_writedata[7:0];
			end
			if (avs_write && avs_address == `DPA_REG_STAT) begin
				if (avs_writedata[`DPA_STAT_CONT]) begin
					cont_ff <= 1'b0;
				end
				if (avs_writedata[`DPA_STAT_ERR]) begin
					err_ff <= 1'b0;
				end
			end
			if (avs_write && avs_address == `DPA_REG_CTRL && busy) begin
				err_ff <= 1'b1;
			end
			case (state_ff)
				ST_IDLE: begin
					if (avs_write && avs_address == `DPA_REG_CTRL) begin
						master_ff <= avs_writedata[`DPA_CTRL_MASTER];
						if (avs_writedata[`DPA_CTRL_GO]) begin
							wr_ff <= avs_writedata[`DPA_CTRL_WR];
							flag_ff <= avs_writedata[`DPA_CTRL_FLAG];
							// Address and mode settle before any select is asserted.
							left_address_bus <= avs_writedata[`DPA_CTRL_FLAG] ?
								{13'h0, addr_ff[`DPA_FLAG_ADDR_W-1:0]} : addr_ff;
							left_write_not_read <= ~avs_writedata[`DPA_CTRL_WR];
							cnt_ff <= `DPA_SETUP_CYC;
							state_ff <= ST_SETUP;
						end
					end
				end
				ST_SETUP: begin
					if (cnt_ff > 4'h1) begin
						cnt_ff <= cnt_ff - 4'h1;
					end else begin
						if (flag_ff) begin
							// Memory stays deselected during a flag access.
							left_flag_select_n <= 1'b0;
						end else begin
							left_low_active_select_n <= 1'b0;
							left_high_active_select <= 1'b1;
						end
						left_output_enable_n <= wr_ff;
						left_data_bus_oe_n <= ~wr_ff;
						// A flag write only carries data bit zero.
						left_data_bus_out <= flag_ff ? {7'h0, wdata_ff[0]} : wdata_ff;
						cnt_ff <= `DPA_ACCESS_CYC;
						state_ff <= ST_ACCESS;
					end
				end
				ST_ACCESS: begin
					if (cont_sync && !flag_ff) begin
						// Arbitration lost on this port; the write may not have landed.
						cont_ff <= 1'b1;
					end
					if (cnt_ff > 4'h1) begin
						cnt_ff <= cnt_ff - 4'h1;
					end else begin
						if (!wr_ff) begin
							rdata_ff <= data_sync;
						end
						left_low_active_select_n <= 1'b1;
						left_high_active_select <= 1'b0;
						left_flag_select_n <= 1'b1;
						left_output_enable_n <= 1'b1;
						cnt_ff <= `DPA_HOLD_CYC;
						state_ff <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					left_data_bus_oe_n <= 1'b1;
					left_write_not_read <= 1'b1;
					state_ff <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end
endmodule // dpa_port_ctrl

// *** hw/dpa_defines.vh ***
// Constants for the dual-port memory access controller.
`ifndef DPA_DEFINES_VH
`define DPA_DEFINES_VH
`define DPA_REG_CTRL 4'h0
`define DPA_REG_ADDR 4'h1
`define DPA_REG_WDATA 4'h2
`define DPA_REG_STAT 4'h3
`define DPA_REG_RDATA 4'h4
`define DPA_CTRL_GO 0
`define DPA_CTRL_WR 1
`define DPA_CTRL_FLAG 2
`define DPA_CTRL_MASTER 3
`define DPA_STAT_BUSY 0
`define DPA_STAT_CONT 1
`define DPA_STAT_ATTN 2
`define DPA_STAT_ERR 3
`define DPA_SETUP_CYC 4'h2
`define DPA_ACCESS_NS 35
`define DPA_ACCESS_CYC 4'h7
`define DPA_HOLD_CYC 4'h1
`define DPA_FLAG_ADDR_W 3
`endif

// *** hw/dpa_sync.v ***
// Two-flop synchroniser for one bit from outside the clock domain.
module dpa_sync (
	clk_sys,
	rst_n,
	d_in,
	q_out
);
	input wire clk_sys;
	input wire rst_n;
	input wire d_in;
	output reg q_out;
	reg meta_ff;
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			meta_ff <= 1'b0;
			q_out <= 1'b0;
		end else begin
			meta_ff <= d_in;
			q_out <= meta_ff;
		end
	end
endmodule // dpa_sync

// *** tb/dpa_chk_assertions.sv ***
// Pin-level checks on the port controller.
module dpa_chk (
	input wire clk_sys,
	input wire rst_n,
	input wire avs_read,
	input wire avs_waitrequest,
	input wire left_low_active_select_n,
	input wire left_high_active_select,
	input wire left_write_not_read,
	input wire left_output_enable_n,
	input wire left_flag_select_n,
	input wire left_data_bus_oe_n,
	input wire [15:0] left_address_bus
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire s = !left_low_active_select_n;
	wire f = !left_flag_select_n;
	a_sel_pair: assert property (s == left_high_active_select) else $error("selects disagree");
	a_flag_excl: assert property (f |-> !s) else $error("flag with memory");
	a_drive_wr: assert property (!left_data_bus_oe_n |-> !left_write_not_read) else $error("drive in read");
	a_no_fight: assert property (!left_data_bus_oe_n |-> left_output_enable_n) else $error("bus fight");
	a_mem_len: assert property ($rose(s) |-> s [*7] ##1 !s) else $error("access length");
	a_flag_len: assert property ($rose(f) |-> f [*7] ##1 !f) else $error("flag length");
	a_addr_hold: assert property (s || f |-> $stable(left_address_bus)) else $error("address moved");
	a_dir_hold: assert property (s || f |-> $stable(left_write_not_read)) else $error("direction moved");
	a_read_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("read wait");
endmodule // dpa_chk
bind dpa_port_ctrl dpa_chk u_dpa_chk (.*);

// *** tb/dpa_mem_model.sv ***
// Behavioural model of one port of the dual-port memory.
module dpa_mem_model (
	input wire left_low_active_select_n,
	input wire left_high_active_select,
	input wire left_write_not_read,
	input wire left_output_enable_n,
	input wire left_flag_select_n,
	input wire left_data_bus_oe_n,
	input wire cascade_master,
	input wire busy_req,
	input wire attn_req,
	input wire [15:0] left_address_bus,
	input wire [7:0] left_data_bus_out,
	output wire [7:0] left_data_bus_in,
	output wire left_contention_flag_n,
	output wire left_attention_flag_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// Whole-byte cells, so a write never leaves a mixed value.
	logic [7:0] mem [0:65535];
	logic [7:0] flg = 8'h00;
	logic [7:0] last = 8'h00;
	wire sel = !left_low_active_select_n && left_high_active_select;
	wire fsel = !left_flag_select_n && !sel;
	wire cdrv = !left_data_bus_oe_n;
	wire ddrv = left_write_not_read && !left_output_enable_n && (sel || fsel);
	wire [7:0] rd = fsel ? {8{flg[left_address_bus[2:0]]}} : mem[left_address_bus];
	always @* begin
		if (!left_write_not_read && cdrv && sel) mem[left_address_bus] = left_data_bus_out;
		if (!left_write_not_read && cdrv && fsel) flg[left_address_bus[2:0]] = left_data_bus_out[0];
	end
	always @* if (cdrv) last = left_data_bus_out; else if (ddrv) last = rd;
	// A released bus shows the inverse, so stale data cannot pass as fresh.
	assign left_data_bus_in = cdrv ? left_data_bus_out : ddrv ? rd : ~last;
	assign left_contention_flag_n = !(cascade_master && busy_req && sel);
	assign left_attention_flag_n = !attn_req;
endmodule // dpa_mem_model

// *** tb/dpa_port_ctrl_test.sv ***
// Self-checking bench for the port controller.
module dpa_port_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'h0, rst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0, busy_req = 1'h0, attn_req = 1'h0;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, q;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, left_low_active_select_n, left_high_active_select, left_write_not_read;
	wire left_output_enable_n, left_flag_select_n, left_data_bus_oe_n, cascade_master;
	wire left_contention_flag_n, left_attention_flag_n;
	wire [15:0] left_address_bus;
	wire [7:0] left_data_bus_in, left_data_bus_out;
	int error_cnt = 0, cmp_count = 0, cyc = 0;
	initial forever #2.5 clk_sys = ~clk_sys;
	dpa_port_ctrl u_dpa_port_ctrl (.*);
	dpa_mem_model u_dpa_mem_model (.*);
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			close_out;
		end
	end
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// The request stands until a rising edge sees waitrequest low; read data is taken at that same edge.
	task automatic bus(logic r, logic [3:0] a, logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= r;
		avs_write <= !r;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'h0) @(posedge clk_sys);
		q = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
	endtask
	task automatic op(logic [3:0] c, logic [15:0] a, logic [7:0] d);
		bus(1'h0, 4'h1, a);
		bus(1'h0, 4'h2, d);
		bus(1'h0, 4'h0, c);
		do bus(1'h1, 4'h3, 32'h0); while (q[0] !== 1'h0);
	endtask
	task automatic t_reset;
		bus(1'h1, 4'h0, 32'h0);
		chk("ctrl", q, 32'h8);
		chk("data float", left_data_bus_oe_n, 32'h1);
		chk("select", left_low_active_select_n, 32'h1);
		bus(1'h1, 4'h9, 32'h0);
		chk("unmapped", q, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_mem;
		op(4'hb, 16'hffff, 8'ha5);
		op(4'hb, 16'h0000, 8'h3c);
		chk("cell", u_dpa_mem_model.mem[16'hffff], 32'ha5);
		op(4'h9, 16'hffff, 8'h00);
		bus(1'h1, 4'h4, 32'h0);
		chk("read top", q, 32'ha5);
		op(4'h9, 16'h0000, 8'h00);
		bus(1'h1, 4'h4, 32'h0);
		chk("read low", q, 32'h3c);
		$display("test memory done");
	endtask
	task automatic t_flag;
		op(4'hf, 16'h0005, 8'h01);
		op(4'hd, 16'h0005, 8'h00);
		bus(1'h1, 4'h4, 32'h0);
		chk("flag set", q, 32'hff);
		op(4'hd, 16'h0004, 8'h00);
		bus(1'h1, 4'h4, 32'h0);
		chk("flag clear", q, 32'h0);
		$display("test flag done");
	endtask
	task automatic t_status;
		busy_req <= 1'h1;
		attn_req <= 1'h1;
		op(4'h9, 16'hffff, 8'h00);
		chk("contention", q[2:1], 32'h3);
		bus(1'h0, 4'h3, 32'h2);
		attn_req <= 1'h0;
		bus(1'h1, 4'h3, 32'h0);
		chk("cleared", q[1], 32'h0);
		bus(1'h0, 4'h0, 32'h1);
		bus(1'h0, 4'h0, 32'h1);
		chk("slave role", cascade_master, 32'h0);
		op(4'h1, 16'h0000, 8'h00);
		chk("refused", q[3:1], 32'h4);
		bus(1'h0, 4'h3, 32'h8);
		bus(1'h1, 4'h3, 32'h0);
		chk("error cleared", q[3], 32'h0);
		busy_req <= 1'h0;
		$display("test status done");
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'h1;
		t_reset;
		t_mem;
		t_flag;
		t_status;
		close_out;
	end
endmodule // dpa_port_ctrl_test
